// ---- common/rsfl_pkg.sv ----
// rsfl_pkg: constants, register map and rail state codes of the rail state / fault log block
// assumes a 125 MHz core clock and a 32-bit APB register bus
package rsfl_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint CLK_HZ     = 125_000_000;
  localparam longint INIT_MS    = 40;
  localparam longint INIT_CYC   = INIT_MS * CLK_HZ / 1000;
  localparam longint PEAK_S     = 30;
  localparam longint PEAK_CYC   = PEAK_S * CLK_HZ;
  localparam longint TICK_MS    = 1;
  localparam longint TICK_CYC   = TICK_MS * CLK_HZ / 1000;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_CTRL    = 8'h04;
  localparam logic [7:0] OFS_TON     = 8'h08;
  localparam logic [7:0] OFS_TOFF    = 8'h0C;
  localparam logic [7:0] OFS_TOFFMAX = 8'h10;
  localparam logic [7:0] OFS_RTC     = 8'h14;
  localparam logic [7:0] OFS_RSTCNT  = 8'h18;
  localparam logic [7:0] OFS_PEAK    = 8'h1C;
  localparam logic [7:0] OFS_BBFLT   = 8'h20;
  localparam logic [7:0] OFS_BBEN    = 8'h24;
  localparam logic [7:0] OFS_LOGSEL  = 8'h28;
  localparam logic [7:0] OFS_LOGA    = 8'h2C;
  localparam logic [7:0] OFS_LOGB    = 8'h30;
  localparam logic [7:0] OFS_STATE   = 8'h40;
  // ctrl bits (write one to act)
  localparam int CTRL_CLR_RSTCNT = 0;
  localparam int CTRL_CLR_BB     = 1;
  localparam int CTRL_CLR_ALERT  = 2;
  // status bits
  localparam int STS_ADDR_LSB = 0;
  localparam int STS_BB_VLD   = 8;
  localparam int STS_CFG_BAD  = 9;
  localparam int STS_INIT     = 10;
  // ----------------------------------------
  // rail state codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    RS_IDLE = 4'b0001,
    RS_SEQON = 4'b0010,
    RS_SDLY = 4'b0011,
    RS_RUP = 4'b0100,
    RS_REG = 4'b0101,
    RS_SOFF = 4'b0110,
    RS_PDLY = 4'b0111,
    RS_RDN = 4'b1000
  } rsfl_state_e;

  function automatic logic [6:0] rsfl_strap_addr(input logic [2:0] s);
    case (s)
      3'h0: rsfl_strap_addr = 7'h11;
      3'h1: rsfl_strap_addr = 7'h13;
      3'h2: rsfl_strap_addr = 7'h17;
      3'h3: rsfl_strap_addr = 7'h31;
      3'h4: rsfl_strap_addr = 7'h33;
      3'h5: rsfl_strap_addr = 7'h71;
      3'h6: rsfl_strap_addr = 7'h73;
      default: rsfl_strap_addr = 7'h77;
    endcase
  endfunction
endpackage

// ---- rtl/rsfl_top.sv ----
// rsfl_top: rail state tracking, fault / peak / reset-count logging, first-fault
// snapshot, strap address and init sequence, registers over APB
// assumes synchronous inputs; por_b resets the non-volatile image, rst_b the rest
`timescale 1ns/1ps
module rsfl_top #(
  parameter int NRAIL     = 32,
  parameter int LOG_DEPTH = 4,
  parameter int INIT_CYC  = int'(rsfl_pkg::INIT_CYC),
  // 30 s of cycles does not fit a signed int
  parameter longint PEAK_CYC = rsfl_pkg::PEAK_CYC,
  parameter int TICK_CYC  = int'(rsfl_pkg::TICK_CYC)
) (
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                por_b,
  input  wire logic                ce,
  input  wire logic [7:0]          paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                addr_strap_bit0,
  input  wire logic                addr_strap_bit1,
  input  wire logic                addr_strap_bit2,
  input  wire logic [NRAIL-1:0]    rail_on_req,
  input  wire logic [NRAIL-1:0]    on_dep_ok,
  input  wire logic [NRAIL-1:0]    off_dep_ok,
  input  wire logic [NRAIL-1:0]    pg_above,
  input  wire logic [NRAIL-1:0]    pg_zero,
  input  wire logic [NRAIL-1:0]    rail_fault,
  input  wire logic [NRAIL-1:0]    fault_retry,
  input  wire logic [NRAIL-1:0]    ramp_done,
  input  wire logic [2:0]          fault_type,
  input  wire logic [NRAIL*12-1:0] rail_volt,
  input  wire logic [11:0]         meas_val,
  input  wire logic                meas_stb,
  input  wire logic                power_down,
  input  wire logic                cfg_sum_ok,
  output logic      [NRAIL-1:0]    rail_en,
  output logic                     io_oe,
  output logic                     bus_alert_out,
  output logic      [6:0]          target_addr
);
  localparam int NW = (NRAIL + 7) / 8;
  localparam int LW = $clog2(LOG_DEPTH);

  rsfl_pkg::rsfl_state_e st_q [NRAIL];
  logic [15:0]      dly_q [NRAIL];
  logic [NRAIL-1:0] ffl_q;
  logic [NRAIL-1:0] fault_evt;
  logic [31:0]      init_cnt_q;
  logic             init_done_q;
  logic             init_fin;
  logic             strap_done_q;
  logic             cfg_bad_q;
  logic [15:0]      ton_q;
  logic [15:0]      toff_q;
  logic [NRAIL-1:0] toff_unl_q;
  logic [31:0]      tick_q;
  logic             tick;
  logic [31:0]      rtc_q;
  logic [31:0]      rtc_nv_q;
  logic [31:0]      since_q;
  logic [31:0]      rst_cnt_q;
  logic [11:0]      peak_nv_q;
  logic [11:0]      peak_ram_q;
  logic [31:0]      pk_cnt_q;
  logic             pk_run_q;
  logic             bb_vld_q;
  logic [31:0]      bb_flt_q;
  logic [31:0]      bb_en_q;
  logic [4:0]       lg_rail_q [LOG_DEPTH];
  logic [2:0]       lg_type_q [LOG_DEPTH];
  logic [11:0]      lg_volt_q [LOG_DEPTH];
  logic [31:0]      lg_time_q [LOG_DEPTH];
  logic             lg_vld_q  [LOG_DEPTH];
  logic             lg_chk_q  [LOG_DEPTH];
  logic [LW-1:0]    lg_wp_q;
  logic [LW-1:0]    lg_sel_q;
  logic             flt_any;
  logic [4:0]       flt_idx;
  logic             wr_en;
  logic [31:0]      rd_d;
  logic             rd_err;

  function automatic logic rec_sum(input logic [4:0] r, input logic [2:0] t,
                                   input logic [11:0] v, input logic [31:0] tm);
    rec_sum = ^{r, t, v, tm};
  endfunction

  assign wr_en = psel & penable & pready & pwrite & ~pslverr;
  assign tick = (tick_q == 32'h0);
  assign init_fin = ~init_done_q & (init_cnt_q == 32'h0);

  // ----------------------------------------
  // init sequence and straps
  // ----------------------------------------
  // counter restarts on every reset exit, pins stay released meanwhile
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      init_cnt_q  <= INIT_CYC - 1;
      init_done_q <= 1'b0;
      io_oe       <= 1'b0;
    end
    else if (ce && !init_done_q)
    begin
      if (init_fin)
      begin
        init_done_q <= 1'b1;
        io_oe       <= 1'b1;
      end
      else
        init_cnt_q <= init_cnt_q - 32'h1;
    end

  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      strap_done_q <= 1'b0;
      target_addr  <= 7'h00;
    end
    else if (ce && !strap_done_q)
    begin
      strap_done_q <= 1'b1;
      target_addr  <= rsfl_pkg::rsfl_strap_addr(
        {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0});
    end

  // ----------------------------------------
  // rail state machines
  // ----------------------------------------
  always_comb
    for (int i = 0; i < NRAIL; i++)
      fault_evt[i] = rail_fault[i] & init_done_q &
        (st_q[i] == rsfl_pkg::RS_RUP || st_q[i] == rsfl_pkg::RS_REG ||
         st_q[i] == rsfl_pkg::RS_SOFF || st_q[i] == rsfl_pkg::RS_PDLY);

  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      for (int i = 0; i < NRAIL; i++)
      begin
        st_q[i]  <= rsfl_pkg::RS_IDLE;
        dly_q[i] <= 16'h0;
      end
      ffl_q   <= '0;
      rail_en <= '0;
    end
    else if (ce && init_done_q)
      for (int i = 0; i < NRAIL; i++)
        if (fault_evt[i])
        begin
          // fault action: enable drops at once, no turn-off delay
          rail_en[i] <= 1'b0;
          ffl_q[i]   <= 1'b1;
          st_q[i]    <= fault_retry[i] ? rsfl_pkg::RS_IDLE : rsfl_pkg::RS_RDN;
        end
        else
          case (st_q[i])
            rsfl_pkg::RS_IDLE:
              if (rail_on_req[i] && !rail_fault[i])
              begin
                ffl_q[i] <= 1'b0;
                st_q[i]  <= rsfl_pkg::RS_SEQON;
              end
            rsfl_pkg::RS_SEQON:
              if (!rail_on_req[i])
                st_q[i] <= rsfl_pkg::RS_IDLE;
              else if (on_dep_ok[i])
              begin
                dly_q[i] <= ton_q;
                st_q[i]  <= rsfl_pkg::RS_SDLY;
              end
            rsfl_pkg::RS_SDLY:
              if (!rail_on_req[i])
                st_q[i] <= rsfl_pkg::RS_IDLE;
              else if (dly_q[i] == 16'h0)
              begin
                rail_en[i] <= 1'b1;
                st_q[i]    <= rsfl_pkg::RS_RUP;
              end
              else if (tick)
                dly_q[i] <= dly_q[i] - 16'h1;
            rsfl_pkg::RS_RUP:
              if (!rail_on_req[i])
                st_q[i] <= rsfl_pkg::RS_SOFF;
              else if (pg_above[i] && !pg_zero[i])
                st_q[i] <= rsfl_pkg::RS_REG;
            rsfl_pkg::RS_REG:
              if (!rail_on_req[i])
                st_q[i] <= rsfl_pkg::RS_SOFF;
            rsfl_pkg::RS_SOFF:
              if (off_dep_ok[i])
              begin
                dly_q[i] <= toff_q;
                st_q[i]  <= rsfl_pkg::RS_PDLY;
              end
            rsfl_pkg::RS_PDLY:
              if (dly_q[i] == 16'h0)
              begin
                rail_en[i] <= 1'b0;
                st_q[i] <= (!toff_unl_q[i] && !fault_retry[i]) ?
                           rsfl_pkg::RS_RDN : rsfl_pkg::RS_IDLE;
              end
              else if (tick)
                dly_q[i] <= dly_q[i] - 16'h1;
            rsfl_pkg::RS_RDN:
              if (ramp_done[i])
                st_q[i] <= rsfl_pkg::RS_IDLE;
            default:
              st_q[i] <= rsfl_pkg::RS_IDLE;
          endcase

  // ----------------------------------------
  // time base, run-time clock, reset count
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      tick_q  <= 32'h0;
      since_q <= 32'h0;
    end
    else if (ce)
    begin
      tick_q <= tick ? TICK_CYC - 1 : tick_q - 32'h1;
      if (tick)
        since_q <= since_q + 32'h1;
    end

  // rtc lives through rst_b; only a power-on wipe clears it
  always_ff @(posedge core_clk or negedge por_b)
    if (!por_b)
    begin
      rtc_q     <= 32'h0;
      rtc_nv_q  <= 32'h0;
      rst_cnt_q <= 32'h0;
    end
    else if (ce)
    begin
      if (wr_en && paddr == rsfl_pkg::OFS_RTC)
        rtc_q <= pwdata;
      else if (tick)
        rtc_q <= rtc_q + 32'h1;
      if (power_down)
        rtc_nv_q <= rtc_q;
      // reset exit counted even if a clear lands on the same edge
      if (init_fin)
        rst_cnt_q <= (wr_en && paddr == rsfl_pkg::OFS_CTRL &&
                      pwdata[rsfl_pkg::CTRL_CLR_RSTCNT]) ? 32'h1 : rst_cnt_q + 32'h1;
      else if (wr_en && paddr == rsfl_pkg::OFS_CTRL && pwdata[rsfl_pkg::CTRL_CLR_RSTCNT])
        rst_cnt_q <= 32'h0;
    end

  // ----------------------------------------
  // peak logging
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge por_b)
    if (!por_b)
    begin
      peak_nv_q  <= 12'h0;
      peak_ram_q <= 12'h0;
      pk_cnt_q   <= 32'h0;
      pk_run_q   <= 1'b0;
    end
    else if (ce)
    begin
      if (pk_run_q && pk_cnt_q == 32'h0)
      begin
        peak_nv_q <= peak_ram_q;
        pk_run_q  <= 1'b0;
      end
      else if (pk_run_q)
      begin
        pk_cnt_q <= pk_cnt_q - 32'h1;
        if (meas_stb && meas_val > peak_ram_q)
          peak_ram_q <= meas_val;
      end
      else if (meas_stb && meas_val > peak_nv_q)
      begin
        pk_run_q   <= 1'b1;
        pk_cnt_q   <= 32'(PEAK_CYC - 1);
        peak_ram_q <= meas_val;
      end
    end

  // ----------------------------------------
  // fault log and first-fault snapshot
  // ----------------------------------------
  // one record per cycle: simultaneous faults keep the lowest rail only
  always_comb
  begin
    flt_any = 1'b0;
    flt_idx = 5'h0;
    for (int i = NRAIL - 1; i >= 0; i--)
      if (fault_evt[i])
      begin
        flt_any = 1'b1;
        flt_idx = 5'(i);
      end
  end

  always_ff @(posedge core_clk or negedge por_b)
    if (!por_b)
    begin
      for (int k = 0; k < LOG_DEPTH; k++)
      begin
        lg_rail_q[k] <= 5'h0;
        lg_type_q[k] <= 3'h0;
        lg_volt_q[k] <= 12'h0;
        lg_time_q[k] <= 32'h0;
        lg_vld_q[k]  <= 1'b0;
        lg_chk_q[k]  <= 1'b0;
      end
      lg_wp_q <= '0;
    end
    else if (ce)
    begin
      if (init_fin)
        for (int k = 0; k < LOG_DEPTH; k++)
          if (lg_chk_q[k] != rec_sum(lg_rail_q[k], lg_type_q[k], lg_volt_q[k], lg_time_q[k]))
            lg_vld_q[k] <= 1'b0;
      if (flt_any)
      begin
        lg_rail_q[lg_wp_q] <= flt_idx;
        lg_type_q[lg_wp_q] <= fault_type;
        lg_volt_q[lg_wp_q] <= rail_volt[flt_idx*12 +: 12];
        lg_time_q[lg_wp_q] <= since_q;
        lg_vld_q[lg_wp_q]  <= 1'b1;
        lg_chk_q[lg_wp_q]  <= rec_sum(flt_idx, fault_type,
                                      rail_volt[flt_idx*12 +: 12], since_q);
        lg_wp_q <= lg_wp_q + 1'b1;
      end
    end

  always_ff @(posedge core_clk or negedge por_b)
    if (!por_b)
    begin
      bb_vld_q <= 1'b0;
      bb_flt_q <= 32'h0;
      bb_en_q  <= 32'h0;
    end
    else if (ce)
    begin
      if (flt_any && !bb_vld_q)
      begin
        bb_vld_q <= 1'b1;
        bb_flt_q <= 32'(rail_fault);
        bb_en_q  <= 32'(rail_en);
      end
      else if (wr_en && paddr == rsfl_pkg::OFS_CTRL && pwdata[rsfl_pkg::CTRL_CLR_BB])
        bb_vld_q <= 1'b0;
    end

  // ----------------------------------------
  // stored configuration and APB slave
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge por_b)
    if (!por_b)
    begin
      ton_q      <= 16'h0;
      toff_q     <= 16'h0;
      toff_unl_q <= '1;
    end
    else if (ce)
    begin
      if (init_fin && !cfg_sum_ok)
      begin
        ton_q      <= 16'h0;
        toff_q     <= 16'h0;
        toff_unl_q <= '1;
      end
      else if (wr_en && paddr == rsfl_pkg::OFS_TON)
        ton_q <= pwdata[15:0];
      else if (wr_en && paddr == rsfl_pkg::OFS_TOFF)
        toff_q <= pwdata[15:0];
      else if (wr_en && paddr == rsfl_pkg::OFS_TOFFMAX)
        toff_unl_q <= pwdata[NRAIL-1:0];
    end

  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      cfg_bad_q     <= 1'b0;
      bus_alert_out <= 1'b0;
      lg_sel_q      <= '0;
    end
    else if (ce)
    begin
      if (init_fin && !cfg_sum_ok)
      begin
        cfg_bad_q     <= 1'b1;
        bus_alert_out <= 1'b1;
      end
      else if (wr_en && paddr == rsfl_pkg::OFS_CTRL && pwdata[rsfl_pkg::CTRL_CLR_ALERT])
      begin
        cfg_bad_q     <= 1'b0;
        bus_alert_out <= 1'b0;
      end
      if (wr_en && paddr == rsfl_pkg::OFS_LOGSEL)
        lg_sel_q <= pwdata[LW-1:0];
    end

  always_comb
  begin
    rd_d   = 32'h0;
    rd_err = 1'b0;
    case (paddr)
      rsfl_pkg::OFS_STATUS:
      begin
        rd_d[rsfl_pkg::STS_ADDR_LSB +: 7] = target_addr;
        rd_d[rsfl_pkg::STS_BB_VLD]  = bb_vld_q;
        rd_d[rsfl_pkg::STS_CFG_BAD] = cfg_bad_q;
        rd_d[rsfl_pkg::STS_INIT]    = ~init_done_q;
      end
      rsfl_pkg::OFS_CTRL:    rd_d = 32'h0;
      rsfl_pkg::OFS_TON:     rd_d = {16'h0, ton_q};
      rsfl_pkg::OFS_TOFF:    rd_d = {16'h0, toff_q};
      rsfl_pkg::OFS_TOFFMAX: rd_d = 32'(toff_unl_q);
      rsfl_pkg::OFS_RTC:     rd_d = rtc_q;
      rsfl_pkg::OFS_RSTCNT:  rd_d = rst_cnt_q;
      rsfl_pkg::OFS_PEAK:    rd_d = {20'h0, peak_nv_q};
      rsfl_pkg::OFS_BBFLT:   rd_d = bb_flt_q;
      rsfl_pkg::OFS_BBEN:    rd_d = bb_en_q;
      rsfl_pkg::OFS_LOGSEL:  rd_d = 32'(lg_sel_q);
      rsfl_pkg::OFS_LOGA:
        rd_d = {lg_vld_q[lg_sel_q], 10'h0, lg_rail_q[lg_sel_q], 1'b0,
                lg_type_q[lg_sel_q], lg_volt_q[lg_sel_q]};
      rsfl_pkg::OFS_LOGB:    rd_d = lg_time_q[lg_sel_q];
      default:
        if (paddr >= rsfl_pkg::OFS_STATE && paddr[1:0] == 2'h0 &&
            32'(paddr - rsfl_pkg::OFS_STATE) < 32'(NW * 4))
        begin
          for (int j = 0; j < 8; j++)
            if (32'((paddr - rsfl_pkg::OFS_STATE) >> 2) * 8 + j < NRAIL)
              rd_d[j*4 +: 4] = st_q[((paddr - rsfl_pkg::OFS_STATE) >> 2) * 8 + j];
        end
        else
          rd_err = 1'b1;
    endcase
  end

  // no wait state: data registered in setup, pready in first access cycle
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      if (psel && !penable)
      begin
        prdata  <= pwrite ? 32'h0 : rd_d;
        pslverr <= rd_err;
        pready  <= 1'b1;
      end
      else
      begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  enable_state_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    rail_en[0] == (st_q[0] inside {rsfl_pkg::RS_RUP, rsfl_pkg::RS_REG,
                                   rsfl_pkg::RS_SOFF, rsfl_pkg::RS_PDLY}))
    else $error("rail enable disagrees with state");
  zero_pg_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && init_done_q && st_q[0] == rsfl_pkg::RS_RUP && pg_zero[0] && rail_on_req[0]
    && !rail_fault[0] |=> st_q[0] == rsfl_pkg::RS_RUP)
    else $error("zero threshold rail left ramp state");
  reg_entry_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && init_done_q && st_q[0] == rsfl_pkg::RS_RUP && pg_above[0] && !pg_zero[0]
    && rail_on_req[0] && !rail_fault[0] |=> st_q[0] == rsfl_pkg::RS_REG)
    else $error("rail missed regulation entry");
  reg_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && st_q[0] == rsfl_pkg::RS_REG && rail_on_req[0] && !rail_fault[0]
    |=> st_q[0] == rsfl_pkg::RS_REG)
    else $error("regulation left without cause");
  init_hiz_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !init_done_q |-> !io_oe && rail_en == '0)
    else $error("pins driven during init");
  strap_map_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(strap_done_q) |-> target_addr == rsfl_pkg::rsfl_strap_addr(
      $past({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0})))
    else $error("strap address wrong");
  bb_hold_a: assert property (@(posedge core_clk) disable iff (!por_b)
    bb_vld_q && !wr_en |=> bb_vld_q && $stable(bb_flt_q) && $stable(bb_en_q))
    else $error("snapshot changed while held");
  rst_count_a: assert property (@(posedge core_clk) disable iff (!por_b)
    ce && init_fin && !wr_en |=> rst_cnt_q == $past(rst_cnt_q) + 32'h1)
    else $error("reset count not advanced");
  peak_store_a: assert property (@(posedge core_clk) disable iff (!por_b)
    ce && pk_run_q && pk_cnt_q == 32'h0 |=> peak_nv_q == $past(peak_ram_q) && !pk_run_q)
    else $error("peak not stored at window end");
  rtc_save_a: assert property (@(posedge core_clk) disable iff (!por_b)
    ce && power_down |=> rtc_nv_q == $past(rtc_q))
    else $error("run-time clock not saved");
endmodule // rsfl_top

// ---- verification/rsfl_apb_host.sv ----
// rsfl_apb_host: apb master model for the register bus
// assumes go is a one-cycle pulse given only while idle
`timescale 1ns/1ps
module rsfl_apb_host (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [7:0]  a,
  input  wire logic [31:0] wd,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [31:0]      rd,
  output logic             done
);
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      {psel, penable, pwrite, done, paddr, pwdata, rd} <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (psel && penable && pready)
      begin
        // released address and data lines show the inverse, not a stale value; pwrite keeps its value
        {psel, penable, done, rd} <= {3'b001, prdata};
        paddr <= ~paddr;
        pwdata <= ~pwdata;
      end
      else if (psel)
        penable <= 1'b1;
      else if (go)
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
    end
endmodule // rsfl_apb_host

// ---- verification/rail_state_fault_logging_bench.sv ----
// rail_state_fault_logging_bench: self-checking bench of rsfl_top
// assumes rsfl_apb_host as bus master and a shortened init and tick
`timescale 1ns/1ps
`define CHK(n,e,g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module rail_state_fault_logging_bench;
  logic        core_clk, rst_b, por_b, go, wr, psel, penable, pwrite, pready;
  logic        pslverr, done, io_oe, bus_alert_out, meas_stb, cfg_ok, pdn, serr;
  logic [7:0]  a, paddr;
  logic [31:0] wd, pwdata, prdata, rd, exp_w;
  logic [1:0]  ron, odep, fdep, pg, flt, rail_en, pgz, frt, rdn;
  logic [2:0]  strap, ftype;
  logic [6:0]  target_addr;
  logic [11:0] meas;
  logic [23:0] volt;
  int          err_count, checks_done;
  int          addr_tab [8] = '{17, 19, 23, 49, 51, 113, 115, 119};
  rsfl_apb_host host (.core_clk, .rst_b, .go, .wr, .a, .wd, .pready, .prdata, .psel,
    .penable, .pwrite, .paddr, .pwdata, .rd, .done);
  rsfl_top #(.NRAIL(2), .INIT_CYC(20), .PEAK_CYC(50), .TICK_CYC(4)) DUT (
    .core_clk, .rst_b, .por_b, .ce(1'b1), .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
    .addr_strap_bit2(strap[2]), .rail_on_req(ron), .on_dep_ok(odep), .off_dep_ok(fdep),
    .pg_above(pg), .pg_zero(pgz), .rail_fault(flt), .fault_retry(frt),
    .ramp_done(rdn), .fault_type(ftype), .rail_volt(volt), .meas_val(meas), .meas_stb,
    .power_down(pdn), .cfg_sum_ok(cfg_ok), .rail_en, .io_oe, .bus_alert_out,
    .target_addr);
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    {go, wr, a, wd} <= {1'b1, w, ad, d};
    @(posedge core_clk);
    go <= 1'b0;
    serr = 1'b0;
    // sampled at the edge: values are those launched one edge earlier
    for (n = 0; n < 20 && done !== 1'b1; n++)
    begin
      @(posedge core_clk);
      if (psel && penable && pready)
        serr = pslverr;
    end
    if (n == 20) begin err_count++; close_out(); end
  endtask
  task automatic st(input int e);
    bus(1'b0, 8'h40, 32'h0);
    `CHK("state", e[3:0], rd[3:0])
  endtask
  task automatic boot;
    int n;
    @(posedge core_clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    wt(2);
    `CHK("oe_init", 1'b0, io_oe)
    for (n = 0; n < 200 && io_oe !== 1'b1; n++) wt(1);
    `CHK("oe_run", 1'b1, io_oe)
  endtask
  initial
  begin
    {rst_b, por_b, go, wr, a, wd, ron, odep, fdep, pg, flt, meas, meas_stb} = '0;
    {pgz, frt, rdn, pdn, serr} = '0;
    {cfg_ok, strap, err_count, checks_done} = {1'b1, 3'h0, 64'h0};
    void'($urandom(32'h4DE0));
    volt = 24'($urandom);
    ftype = 3'($urandom);
    wt(6);
    boot();
    for (int s = 0; s < 8; s++)
    begin
      strap <= s[2:0];
      cfg_ok <= (s != 7);
      wt(1);
      rst_b <= 1'b0;
      wt(2);
      boot();
      `CHK("addr", addr_tab[s][6:0], target_addr)
    end
    bus(1'b0, 8'h18, 32'h0);
    `CHK("rstcnt", 32'h9, rd)
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b0, 8'h18, 32'h0);
    `CHK("rstcnt_clr", 32'h0, rd)
    bus(1'b0, 8'h00, 32'h0);
    `CHK("cfg_bad", 2'b11, {bus_alert_out, rd[9]})
    bus(1'b1, 8'h04, 32'h4);
    `CHK("alert_clr", 1'b0, bus_alert_out)
    $display("init and strap test done");
    bus(1'b1, 8'h08, 32'h3);
    bus(1'b1, 8'h0C, 32'hA);
    ron <= 2'h1;
    wt(3);
    st(2);
    odep <= 2'h1;
    st(3);
    wt(20);
    st(4);
    `CHK("en_on", 1'b1, rail_en[0])
    pg <= 2'h1;
    st(5);
    pg <= 2'h0;
    st(5);
    ron <= 2'h0;
    st(6);
    fdep <= 2'h1;
    st(7);
    wt(50);
    st(1);
    `CHK("en_off", 1'b0, rail_en[0])
    $display("rail walk test done");
    ron <= 2'h1;
    pg <= 2'h1;
    wt(25);
    flt <= 2'h1;
    wt(2);
    flt <= 2'h0;
    st(8);
    bus(1'b1, 8'h28, 32'h0);
    bus(1'b0, 8'h2C, 32'h0);
    exp_w = 32'h80000000 | (32'(ftype) << 12) | 32'(volt[11:0]);
    `CHK("log", exp_w, rd)
    bus(1'b0, 8'h00, 32'h0);
    `CHK("snap", 1'b1, rd[8])
    bus(1'b0, 8'h20, 32'h0);
    `CHK("snap_flt", 32'h1, rd)
    bus(1'b0, 8'h24, 32'h0);
    `CHK("snap_en", 32'h1, rd)
    bus(1'b1, 8'h04, 32'h2);
    bus(1'b0, 8'h00, 32'h0);
    `CHK("snap_clr", 1'b0, rd[8])
    // ramp-down ends, rail re-sequences against a zero threshold
    pgz <= 2'h1;
    rdn <= 2'h1;
    wt(25);
    st(4);
    `CHK("en_zero_pg", 1'b1, rail_en[0])
    frt <= 2'h1;
    flt <= 2'h1;
    wt(2);
    flt <= 2'h0;
    ron <= 2'h0;
    st(1);
    bus(1'b0, 8'h00, 32'h0);
    `CHK("snap_again", 1'b1, rd[8])
    $display("fault test done");
    exp_w = 32'h400 | ($urandom & 32'h3FF);
    meas <= exp_w[11:0];
    meas_stb <= 1'b1;
    pdn <= 1'b1;
    wt(1);
    exp_w = exp_w + 32'h100;
    meas <= exp_w[11:0];
    pdn <= 1'b0;
    wt(1);
    meas_stb <= 1'b0;
    wt(60);
    bus(1'b0, 8'h1C, 32'h0);
    `CHK("peak", exp_w, rd)
    exp_w = $urandom;
    bus(1'b1, 8'h14, exp_w);
    bus(1'b0, 8'h14, 32'h0);
    `CHK("rtc", 1'b1, (rd - exp_w) <= 32'h1)
    bus(1'b0, 8'h34, 32'h0);
    `CHK("slverr", 1'b1, serr)
    $display("peak and clock test done");
    close_out();
  end
endmodule // rail_state_fault_logging_bench
